// *** src/hbsr_pkg.sv ***
// Purpose: Shared constants and types for the host bus select/ready logic
// Assumes: Core clock 50 MHz, host bus clock at most 50 MHz
// Notes:   Package only, no logic
package hbsr_pkg;

	localparam int          CORE_CLK_MHZ    = 50;
	localparam int          BUS_CLK_MAX_MHZ = 50;
	localparam int          SYNC_STAGES     = 2;
	localparam int          ADDR_MSB        = 15;
	localparam int          DECODE_LSB      = 4;
	localparam int          INT_BITS_DEF    = 16;
	localparam logic        READY_IDLE      = 1'b1;
	localparam logic        IRQ_IDLE        = 1'b1;
	localparam logic [15:0] BASE_ADDR_DEF   = 16'h0300;

	typedef enum logic [1:0] {
		LNK_IDLE,
		LNK_WAIT,
		LNK_READY
	} hbsr_link_t;

endpackage : hbsr_pkg

// *** src/hbsr_sync.sv ***
// Purpose: Two flip-flop level synchroniser
// Assumes: Input is a level that holds for more than a destination period
// Notes:   First stage is read only by the second stage
`timescale 1ns/1ps
module hbsr_sync #(
	parameter int  WIDTH     = 1,
	parameter bit  RESET_VAL = 1'b0
) (
	input  wire logic             clk,
	input  wire logic             reset,
	input  wire logic [WIDTH-1:0] din,
	output logic      [WIDTH-1:0] dout
);

	logic [WIDTH-1:0] stage1_q;
	logic [WIDTH-1:0] stage2_q;

	always_ff @(posedge clk) begin
		if (reset) begin
			stage1_q <= {WIDTH{RESET_VAL}};
			stage2_q <= {WIDTH{RESET_VAL}};
		end else begin
			stage1_q <= din;
			stage2_q <= stage1_q;
		end
	end

	assign dout = stage2_q;

endmodule : hbsr_sync

// *** src/hbsr_host_port.sv ***
// Purpose: Host bus select, ready handshake, local decode and interrupt pin
// Assumes: Host pins are synchronous to busClk; core side runs on clk
// Notes:   Requests cross by toggle; ready is registered on busClk
`timescale 1ns/1ps
// Overview of operation
// - Data select picks the queue data halves; wide bus variant only.
// - Data select grants access ignoring qualifier and address.
// - In synchronous mode a falling ready edge on busClk ends the access.
// - In burst mode ready stays low while wait states are inserted.
// - Interrupt pin goes low while any interrupt status bit is set.
// - Local hit asserts when qualifier low and A15-A4 match base address.
// - Local hit is a pure combinational decode, no register stage.
module hbsr_host_port #(
	parameter bit          WIDE_BUS  = 1'b1,
	parameter int          INT_BITS  = hbsr_pkg::INT_BITS_DEF
) (
	input  wire logic                clk,
	input  wire logic                reset,
	input  wire logic                busClk,
	input  wire logic [15:1]         address,
	input  wire logic                address_qualifier_n,
	input  wire logic                queue_data_select_n,
	input  wire logic                cycle_marker_n,
	input  wire logic                sync_write_read,
	input  wire logic                host_ready_return_n,
	input  wire logic                bus_mode_strap,
	input  wire logic [15:0]         baseAddress,
	input  wire logic [INT_BITS-1:0] intStatus,
	input  wire logic                coreDone,
	output logic                     local_device_hit_n,
	output logic                     sync_ready_n,
	output logic                     irq_out_n,
	output logic                     dataBusOe,
	output logic                     accessReq,
	output logic                     accessWrite,
	output logic                     accessQueueData
);

	function automatic logic addrHit(input logic [15:1] addr,
	                                 input logic        qualN,
	                                 input logic [15:0] base);
		addrHit = !qualN && (addr[hbsr_pkg::ADDR_MSB:hbsr_pkg::DECODE_LSB]
		          == base[hbsr_pkg::ADDR_MSB:hbsr_pkg::DECODE_LSB]);
	endfunction : addrHit

	// Combinational decode, no flop in the path
	assign local_device_hit_n = !addrHit(address, address_qualifier_n,
	                                     baseAddress);

	// Bus domain reset and strap
	logic busRst;
	logic strapSync;
	logic doneSync;
	logic reqSync;

	hbsr_sync #(.WIDTH(1), .RESET_VAL(1'b1)) u_rst_sync (
		.clk   (busClk),
		.reset (1'b0),
		.din   (reset),
		.dout  (busRst)
	);

	// Runs through reset so the strap has settled before its capture
	hbsr_sync #(.WIDTH(1), .RESET_VAL(1'b0)) u_strap_sync (
		.clk   (busClk),
		.reset (1'b0),
		.din   (bus_mode_strap),
		.dout  (strapSync)
	);

	hbsr_pkg::hbsr_link_t state_q, state_d;
	logic burst_q, burst_d;
	logic strapDone_q, strapDone_d;
	logic reqTog_q, reqTog_d;
	logic doneSeen_q, doneSeen_d;
	logic write_q, write_d;
	logic queueSel_q, queueSel_d;
	logic srdy_q, srdy_d;
	logic oe_q, oe_d;
	logic queueSelect;
	logic selectAny;
	logic doneEvent;

	assign queueSelect = WIDE_BUS && !queue_data_select_n;
	assign selectAny   = queueSelect ||
	                     addrHit(address, address_qualifier_n,
	                             baseAddress);
	assign doneEvent   = doneSync != doneSeen_q;

	always_comb begin
		state_d     = state_q;
		burst_d     = burst_q;
		strapDone_d = 1'b1;
		reqTog_d    = reqTog_q;
		doneSeen_d  = doneSeen_q;
		write_d     = write_q;
		queueSel_d  = queueSel_q;
		// Strap caught once after reset release
		if (!strapDone_q) begin
			burst_d = WIDE_BUS && strapSync;
		end
		unique case (state_q)
			hbsr_pkg::LNK_IDLE: begin
				// Burst needs no cycle marker, it only gives direction
				if (strapDone_q && selectAny &&
				    (burst_q || !cycle_marker_n)) begin
					state_d    = hbsr_pkg::LNK_WAIT;
					reqTog_d   = !reqTog_q;
					write_d    = sync_write_read;
					queueSel_d = queueSelect;
				end
			end
			hbsr_pkg::LNK_WAIT: begin
				if (doneEvent) begin
					doneSeen_d = doneSync;
					state_d    = hbsr_pkg::LNK_READY;
				end
			end
			hbsr_pkg::LNK_READY: begin
				// Burst completion waits while the host inserts waits
				if (!burst_q || host_ready_return_n) begin
					state_d = hbsr_pkg::LNK_IDLE;
				end
			end
		endcase
		srdy_d = !((burst_q && state_d == hbsr_pkg::LNK_WAIT) ||
		           (!burst_q && state_d == hbsr_pkg::LNK_READY));
		oe_d   = (state_d != hbsr_pkg::LNK_IDLE) && !write_d;
	end

	always_ff @(posedge busClk) begin
		if (busRst) begin
			state_q     <= hbsr_pkg::LNK_IDLE;
			burst_q     <= 1'b0;
			strapDone_q <= 1'b0;
			reqTog_q    <= 1'b0;
			doneSeen_q  <= 1'b0;
			write_q     <= 1'b0;
			queueSel_q  <= 1'b0;
			srdy_q      <= hbsr_pkg::READY_IDLE;
			oe_q        <= 1'b0;
		end else begin
			state_q     <= state_d;
			burst_q     <= burst_d;
			strapDone_q <= strapDone_d;
			reqTog_q    <= reqTog_d;
			doneSeen_q  <= doneSeen_d;
			write_q     <= write_d;
			queueSel_q  <= queueSel_d;
			srdy_q      <= srdy_d;
			oe_q        <= oe_d;
		end
	end

	assign sync_ready_n = srdy_q;
	assign dataBusOe    = oe_q;

	// Core domain: request edge, done toggle, interrupt pin
	hbsr_sync #(.WIDTH(1), .RESET_VAL(1'b0)) u_req_sync (
		.clk   (clk),
		.reset (reset),
		.din   (reqTog_q),
		.dout  (reqSync)
	);

	logic reqSeen_q, reqSeen_d;
	logic req_q, req_d;
	logic accWr_q, accWr_d;
	logic accQd_q, accQd_d;
	logic doneTog_q, doneTog_d;
	logic irq_q, irq_d;

	always_comb begin
		reqSeen_d = reqSync;
		req_d     = reqSync != reqSeen_q;
		// Bundled flags are stable while the toggle is in flight
		accWr_d   = req_d ? write_q : accWr_q;
		accQd_d   = req_d ? queueSel_q : accQd_q;
		doneTog_d = coreDone ? !doneTog_q : doneTog_q;
		irq_d     = !(|intStatus);
	end

	always_ff @(posedge clk) begin
		if (reset) begin
			reqSeen_q <= 1'b0;
			req_q     <= 1'b0;
			accWr_q   <= 1'b0;
			accQd_q   <= 1'b0;
			doneTog_q <= 1'b0;
			irq_q     <= hbsr_pkg::IRQ_IDLE;
		end else begin
			reqSeen_q <= reqSeen_d;
			req_q     <= req_d;
			accWr_q   <= accWr_d;
			accQd_q   <= accQd_d;
			doneTog_q <= doneTog_d;
			irq_q     <= irq_d;
		end
	end

	hbsr_sync #(.WIDTH(1), .RESET_VAL(1'b0)) u_done_sync (
		.clk   (busClk),
		.reset (busRst),
		.din   (doneTog_q),
		.dout  (doneSync)
	);

	assign accessReq       = req_q;
	assign accessWrite     = accWr_q;
	assign accessQueueData = accQd_q;
	assign irq_out_n       = irq_q;

	// Checks
	a_hit_decode_match: assert property (@(posedge clk) disable iff (reset)
		(!address_qualifier_n && address[15:4] == baseAddress[15:4])
		|-> !local_device_hit_n)
		else $error("Local hit missing on address match");

	a_hit_qualifier_off: assert property (@(posedge clk) disable iff (reset)
		address_qualifier_n |-> local_device_hit_n)
		else $error("Local hit without qualifier");

	a_vlb_ready_pulse: assert property (@(posedge busClk) disable iff (busRst)
		($fell(sync_ready_n) && !burst_q) |=> sync_ready_n)
		else $error("Sync ready low longer than one cycle");

	a_burst_wait_low: assert property (@(posedge busClk) disable iff (busRst)
		(burst_q && state_q == hbsr_pkg::LNK_WAIT) |-> !sync_ready_n)
		else $error("Burst wait without ready low");

	a_burst_host_hold: assert property (@(posedge busClk) disable iff (busRst)
		(burst_q && state_q == hbsr_pkg::LNK_READY && !host_ready_return_n)
		|=> state_q == hbsr_pkg::LNK_READY)
		else $error("Burst ended while host waits");

	a_irq_set_low: assert property (@(posedge clk) disable iff (reset)
		(|intStatus) |=> !irq_out_n)
		else $error("Interrupt pin not low");

	a_irq_clear_high: assert property (@(posedge clk) disable iff (reset)
		!(|intStatus) |=> irq_out_n)
		else $error("Interrupt pin low without status");

	a_queue_start: assert property (@(posedge busClk) disable iff (busRst)
		(state_q == hbsr_pkg::LNK_IDLE && strapDone_q && queueSelect &&
		 (burst_q || !cycle_marker_n)) |=> state_q == hbsr_pkg::LNK_WAIT)
		else $error("Data select access not taken");

	a_unsel_ignored: assert property (@(posedge busClk) disable iff (busRst)
		(state_q == hbsr_pkg::LNK_IDLE && !selectAny)
		|=> (state_q == hbsr_pkg::LNK_IDLE && !dataBusOe))
		else $error("Unselected access taken");

	a_req_one_cycle: assert property (@(posedge clk) disable iff (reset)
		accessReq |=> !accessReq)
		else $error("Access request longer than one cycle");

	c_vlb_access: cover property (@(posedge busClk) disable iff (busRst)
		!burst_q && state_q == hbsr_pkg::LNK_READY);
	c_burst_access: cover property (@(posedge busClk) disable iff (busRst)
		burst_q && state_q == hbsr_pkg::LNK_READY && !host_ready_return_n);
	c_queue_read: cover property (@(posedge clk) disable iff (reset)
		accessReq && accessQueueData && !accessWrite);

endmodule : hbsr_host_port

// *** tb/hbsr_host_model.sv ***
// Purpose: Host bus master model on busClk
// Assumes: Qualifier and select float high when let go
// Notes:   Released address shows its inverse
`timescale 1ns/1ps
module hbsr_host_model (
	input  wire logic        busClk,
	input  wire logic        sync_ready_n,
	input  wire logic        dataBusOe,
	output logic      [15:1] address,
	output logic             address_qualifier_n,
	output logic             queue_data_select_n,
	output logic             cycle_marker_n,
	output logic             sync_write_read,
	output logic             host_ready_return_n,
	output int               lowLen,
	output logic             oeSeen
);
	initial begin
		address = 15'h0;
		address_qualifier_n = 1'b1;
		queue_data_select_n = 1'b1;
		cycle_marker_n = 1'b0;
		sync_write_read = 1'b0;
		host_ready_return_n = 1'b1;
	end
	task automatic xfer(input logic wr, qd, q, bm, hit,
		input logic [15:1] a, input int waits);
		bit fin;
		lowLen = 0;
		oeSeen = 1'b0;
		fin = 1'b0;
		@(posedge busClk);
		#1;
		address = a;
		address_qualifier_n = q;
		queue_data_select_n = !qd;
		sync_write_read = wr;
		cycle_marker_n = bm ? !wr : 1'b0;
		// Held from the start so the device waits in its ready state
		host_ready_return_n = !(waits > 0);
		for (int n = 0; n < 300 && !fin; n++) begin
			@(posedge busClk);
			oeSeen |= dataBusOe;
			if (!sync_ready_n) lowLen++;
			fin = hit ? lowLen > 0 && (!bm || sync_ready_n) : n == 11;
		end
		repeat (waits) @(posedge busClk);
		#1;
		host_ready_return_n = 1'b1;
		address = ~a;
		address_qualifier_n = 1'b1;
		queue_data_select_n = 1'b1;
		cycle_marker_n = 1'b0;
		sync_write_read = 1'b0;
		// A stuck ready shows up as extra width
		@(posedge busClk);
		if (!sync_ready_n) lowLen++;
	endtask : xfer
endmodule : hbsr_host_model

// *** tb/host_bus_select_ready_logic_tb.sv ***
// Purpose: Self-checking bench for the host select/ready logic
// Assumes: Bench answers the core side, model drives the host side
// Notes:   Strap changes only under reset
`timescale 1ns/1ps
module host_bus_select_ready_logic_tb;
	logic        clk = 1'b0;
	logic        busClk = 1'b0;
	logic        reset = 1'b1;
	logic        bus_mode_strap = 1'b0;
	logic [15:0] baseAddress = hbsr_pkg::BASE_ADDR_DEF;
	logic [15:0] intStatus = 16'h0;
	logic [15:0] prevInt;
	logic        coreDone = 1'b0;
	logic [15:1] address;
	logic        address_qualifier_n, queue_data_select_n;
	logic        cycle_marker_n, sync_write_read, host_ready_return_n;
	logic        local_device_hit_n, sync_ready_n, irq_out_n;
	logic        dataBusOe, accessReq, accessWrite, accessQueueData;
	logic        oeSeen, rs;
	logic [1:0]  e;
	logic [1:0]  expQ[$];
	int          lowLen;
	int          n_errors = 0;
	int          checks_done = 0;

	hbsr_host_port u_dut (.clk, .reset, .busClk, .address,
		.address_qualifier_n, .queue_data_select_n, .cycle_marker_n,
		.sync_write_read, .host_ready_return_n, .bus_mode_strap,
		.baseAddress, .intStatus, .coreDone, .local_device_hit_n,
		.sync_ready_n, .irq_out_n, .dataBusOe, .accessReq,
		.accessWrite, .accessQueueData);
	hbsr_host_model u_host (.busClk, .sync_ready_n, .dataBusOe, .address,
		.address_qualifier_n, .queue_data_select_n, .cycle_marker_n,
		.sync_write_read, .host_ready_return_n, .lowLen, .oeSeen);

	always #10 clk = ~clk;
	// Bench bus clock runs above the host limit; logic is rate blind
	initial #0.7 forever #3 busClk = ~busClk;
	// Only synchronous modes modelled, so the bus clock never stops

	task automatic chk(input bit ok, input string m);
		checks_done++;
		if (!ok) begin
			n_errors++;
			$display("Error at %0t: %s", $time, m);
		end
	endtask : chk

	task automatic close_out;
		$display("Checks %0d, errors %0d", checks_done, n_errors);
		if (n_errors == 0 && checks_done > 0) $display("Test passed");
		else $display("Test failed");
		$finish;
	endtask : close_out

	task automatic run(input logic bm);
		logic [15:1] a;
		logic        wr;
		logic        hit;
		int          k;
		repeat (12) @(posedge busClk);
		for (int i = 0; i < 24; i++) begin
			k = i % 4;
			wr = 1'($urandom);
			hit = k < 2;
			@(posedge busClk);
			#1 baseAddress = 16'($urandom);
			case (k)
				0: a = {baseAddress[15:4], 3'($urandom)};
				1: a = 15'($urandom);
				2: a = {baseAddress[15:4] ^ (12'h1 << $urandom_range(11)),
					3'($urandom)};
				default: a = {baseAddress[15:4], 3'h0};
			endcase
			if (hit) expQ.push_back({wr, k == 1});
			u_host.xfer(wr, k == 1, k != 0 && k != 2, bm, hit, a,
				bm ? $urandom_range(3) : 0);
			chk(expQ.size() == 0, "access count");
			chk(hit ? (bm ? lowLen > 1 : lowLen == 1) : lowLen == 0,
				"ready width");
			chk(oeSeen === (hit && !wr), "data enable");
		end
		$display("Mode %0d tests done", bm);
	endtask : run

	// Core side: one done per request, random latency
	initial forever begin
		@(posedge clk);
		if (accessReq === 1'b1) begin
			e = expQ.size() ? expQ.pop_front() : 2'bxx;
			chk({accessWrite, accessQueueData} === e, "flags");
			repeat ($urandom_range(3)) @(posedge clk);
			#1 coreDone = 1'b1;
			@(posedge clk);
			#1 coreDone = 1'b0;
		end
	end

	initial forever begin
		@(posedge clk);
		rs = reset;
		#1;
		prevInt = intStatus;
		intStatus = $urandom_range(1) ? 16'h0 : 16'h1 << $urandom_range(15);
		@(negedge clk);
		if (!rs) chk(irq_out_n === !(|prevInt), "irq level");
	end

	// Half a cycle after an address change catches a register stage
	always @(negedge busClk)
		chk(local_device_hit_n === !(!address_qualifier_n &&
			address[15:4] === baseAddress[15:4]), "hit");

	initial begin
		void'($urandom(32'hc639));
		repeat (4) @(posedge clk);
		#1 reset = 1'b0;
		run(1'b0);
		@(posedge clk);
		#1 reset = 1'b1;
		bus_mode_strap = 1'b1;
		repeat (4) @(posedge clk);
		#1 reset = 1'b0;
		run(1'b1);
		close_out();
	end

	// Far beyond 48 accesses of a few dozen bus cycles
	initial begin
		#500000;
		n_errors++;
		close_out();
	end
endmodule : host_bus_select_ready_logic_tb
